/* rtl/plc_cal_if.sv */
// Interface between the calibration sequencer and the pump-current selector.
// Assumes both ends share clk_i.
`timescale 1ns/100ps
`default_nettype none
interface plc_cal_if;
    logic       cal_busy;
    logic       cal_done;
    logic [7:0] fb_div;
    logic [2:0] auto_code;
    modport seq (output cal_busy, output cal_done, input auto_code, output fb_div);
    modport sel (input cal_busy, input cal_done, output auto_code, input fb_div);
endinterface
`default_nettype wire

/* rtl/plc_defs.svh */
// Offsets, field positions, reset values and timing counts for the PLL calibration control.
// Assumes inclusion by bare name from rtl files.
`ifndef PLC_DEFS_SVH
`define PLC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLC_OFS_CW_FIRST   8'h00
`define PLC_OFS_CW_THIRD   8'h02
`define PLC_OFS_CW_FOURTH  8'h03
`define PLC_OFS_STATUS     8'h1b
`define PLC_OFS_IRQ_STAT   8'h20
`define PLC_OFS_IRQ_MASK   8'h21
`define PLC_OFS_CLK_INFO   8'h22

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLC_BIT_VCO_CAL    24
`define PLC_BIT_DAC_CAL    24
`define PLC_BIT_PLL_EN     18
`define PLC_BIT_MAN_ICP    6
`define PLC_BIT_LOCK_EN    2
`define PLC_BIT_LOCKED     24
`define PLC_N_LSB          8
`define PLC_ICP_LSB        3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PLC_ICP_RESET      3'h3
`define PLC_N_RESET        8'h0a
`define PLC_N_MIN          8'h0a
`define PLC_ICP_STEP_UA    125

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLC_CLK_NS         10
`define PLC_VCO_CAL_NS     2000
`define PLC_VCO_CAL_CYC    ((`PLC_VCO_CAL_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)
`define PLC_LOCK_NS        1000
`define PLC_LOCK_CYC       ((`PLC_LOCK_NS + `PLC_CLK_NS - 1) / `PLC_CLK_NS)

`endif

/* rtl/plc_icp_sel.sv */
// Automatic pump-current choice taken from the divide value at the end of a calibration.
// Assumes the sequencer raises cal_done for one cycle.
`timescale 1ns/100ps
`default_nettype none
`include "plc_defs.svh"
module plc_icp_sel (
    // Clock, reset, enable
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic en_i,
    // Sequencer side
    plc_cal_if.sel    cal
);
    logic [2:0] nxt_code;
    logic [2:0] code_ff;

    always_comb begin
        if (cal.fb_div <= 8'd23) begin
            nxt_code = 3'h1;
        end else if (cal.fb_div <= 8'd35) begin
            nxt_code = 3'h2;
        end else if (cal.fb_div <= 8'd43) begin
            nxt_code = 3'h3;
        end else if (cal.fb_div <= 8'd55) begin
            nxt_code = 3'h4;
        end else if (cal.fb_div <= 8'd63) begin
            nxt_code = 3'h5;
        end else if (cal.fb_div <= 8'd79) begin
            nxt_code = 3'h6;
        end else begin
            nxt_code = 3'h7;
        end
        if (cal.fb_div <= 8'd15) begin
            nxt_code = 3'h0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_ff <= `PLC_ICP_RESET;
        end else if (en_i && cal.cal_done) begin
            code_ff <= nxt_code;
        end
    end

    assign cal.auto_code = code_ff;
endmodule
`default_nettype wire

/* rtl/plc_pkg.sv */
// Types for the PLL calibration control.
// Assumes nothing beyond a SystemVerilog compiler.
package plc_pkg;
    typedef enum logic [1:0] {
        PLC_IDLE = 2'b00,
        PLC_CAL  = 2'b01,
        PLC_DONE = 2'b11
    } plc_cal_state_t;
endpackage

/* rtl/plc_top.sv */
// PLL calibration control: register port, VCO calibration sequencer, pump current, lock status.
// Assumes a same-clock register master and an asynchronous lock level from the analog PLL.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "plc_defs.svh"
module plc_top #(
    parameter int unsigned VCO_CAL_CYC = `PLC_VCO_CAL_CYC,
    parameter int unsigned LOCK_CYC    = `PLC_LOCK_CYC
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        en_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Analog PLL
    input  wire logic        pll_lock_raw_i,
    output logic             pll_sel_o,
    output logic      [2:0]  pump_current_code_o,
    output logic      [8:0]  pll_mult_o,
    output logic             vco_cal_busy_o,
    output logic             dac_cal_start_o,
    // Interrupt
    output logic             irq_o
);
    plc_cal_if cal ();

    logic        vco_req_ff;
    logic        dac_req_ff;
    logic        pll_en_ff;
    logic        man_icp_ff;
    logic        lock_en_ff;
    logic [7:0]  fb_div_ff;
    logic [2:0]  icp_ff;
    logic [2:0]  irq_stat_ff;
    logic [2:0]  irq_mask_ff;
    logic        lock_s1_ff;
    logic        lock_s2_ff;
    logic        locked_ff;
    logic        locked_d_ff;
    logic        vco_req_d_ff;
    logic        dac_req_d_ff;
    logic [15:0] cal_cnt_ff;
    logic [15:0] lock_cnt_ff;
    plc_pkg::plc_cal_state_t state_ff;
    plc_pkg::plc_cal_state_t nxt_state;
    logic [31:0] nxt_rdata;
    logic [2:0]  evt;
    logic        lock_ok;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vco_req_ff <= 1'b0;
            dac_req_ff <= 1'b0;
            pll_en_ff  <= 1'b0;
            man_icp_ff <= 1'b0;
            lock_en_ff <= 1'b0;
            fb_div_ff  <= `PLC_N_RESET;
            icp_ff     <= `PLC_ICP_RESET;
            irq_mask_ff <= 3'h0;
        end else if (en_i && wr_i) begin
            case (addr_i)
                `PLC_OFS_CW_FIRST: begin
                    vco_req_ff <= wdata_i[`PLC_BIT_VCO_CAL];
                end
                `PLC_OFS_CW_THIRD: begin
                    pll_en_ff  <= wdata_i[`PLC_BIT_PLL_EN];
                    man_icp_ff <= wdata_i[`PLC_BIT_MAN_ICP];
                    lock_en_ff <= wdata_i[`PLC_BIT_LOCK_EN];
                    fb_div_ff  <= wdata_i[`PLC_N_LSB +: 8];
                    icp_ff     <= wdata_i[`PLC_ICP_LSB +: 3];
                end
                `PLC_OFS_CW_FOURTH: begin
                    dac_req_ff <= wdata_i[`PLC_BIT_DAC_CAL];
                end
                `PLC_OFS_IRQ_MASK: begin
                    irq_mask_ff <= wdata_i[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // VCO calibration sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vco_req_d_ff <= 1'b0;
            dac_req_d_ff <= 1'b0;
        end else if (en_i) begin
            vco_req_d_ff <= vco_req_ff;
            dac_req_d_ff <= dac_req_ff;
        end
    end

    // Only a rising request starts a run, so a bit left high never re-arms
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            plc_pkg::PLC_IDLE: begin
                if (vco_req_ff && !vco_req_d_ff) begin
                    nxt_state = plc_pkg::PLC_CAL;
                end
            end
            plc_pkg::PLC_CAL: begin
                if (cal_cnt_ff == 16'(VCO_CAL_CYC - 1)) begin
                    nxt_state = plc_pkg::PLC_DONE;
                end
            end
            plc_pkg::PLC_DONE: begin
                nxt_state = plc_pkg::PLC_IDLE;
            end
            default: begin
                nxt_state = plc_pkg::PLC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff   <= plc_pkg::PLC_IDLE;
            cal_cnt_ff <= 16'h0000;
        end else if (en_i) begin
            state_ff <= nxt_state;
            if (state_ff == plc_pkg::PLC_CAL) begin
                cal_cnt_ff <= cal_cnt_ff + 16'h0001;
            end else begin
                cal_cnt_ff <= 16'h0000;
            end
        end
    end

    assign cal.cal_busy = (state_ff == plc_pkg::PLC_CAL);
    assign cal.cal_done = (state_ff == plc_pkg::PLC_DONE);
    assign cal.fb_div   = fb_div_ff;

    plc_icp_sel u_icp_sel (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .en_i      (en_i),
        .cal       (cal)
    );

    // ----------------------------------------
    // Lock detection
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
        end else if (en_i) begin
            lock_s1_ff <= pll_lock_raw_i;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    // gate by enable and PLL path, and hold off while calibration is busy
    assign lock_ok = lock_s2_ff && lock_en_ff && pll_en_ff && !cal.cal_busy;

    // Lock must hold for a while so a brief glitch never reports lock
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_cnt_ff <= 16'h0000;
            locked_ff   <= 1'b0;
            locked_d_ff <= 1'b0;
        end else if (en_i) begin
            locked_d_ff <= locked_ff;
            if (!lock_ok) begin
                lock_cnt_ff <= 16'h0000;
                locked_ff   <= 1'b0;
            end else if (lock_cnt_ff == 16'(LOCK_CYC - 1)) begin
                locked_ff <= 1'b1;
            end else begin
                lock_cnt_ff <= lock_cnt_ff + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Interrupts: 0 cal done, 1 lock gained, 2 lock lost
    // ----------------------------------------
    assign evt = {locked_d_ff && !locked_ff, locked_ff && !locked_d_ff, cal.cal_done};

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_ff <= 3'h0;
        end else if (en_i) begin
            if (wr_i && addr_i == `PLC_OFS_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wdata_i[2:0]) | evt;
            end else begin
                irq_stat_ff <= irq_stat_ff | evt;
            end
        end
    end

    // ----------------------------------------
    // Outputs and read data
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (addr_i)
            `PLC_OFS_CW_FIRST:  nxt_rdata[`PLC_BIT_VCO_CAL] = vco_req_ff;
            `PLC_OFS_CW_THIRD: begin
                nxt_rdata[`PLC_BIT_PLL_EN]  = pll_en_ff;
                nxt_rdata[`PLC_BIT_MAN_ICP] = man_icp_ff;
                nxt_rdata[`PLC_BIT_LOCK_EN] = lock_en_ff;
                nxt_rdata[`PLC_N_LSB +: 8]  = fb_div_ff;
                nxt_rdata[`PLC_ICP_LSB +: 3] = icp_ff;
            end
            `PLC_OFS_CW_FOURTH: nxt_rdata[`PLC_BIT_DAC_CAL] = dac_req_ff;
            `PLC_OFS_STATUS:    nxt_rdata[`PLC_BIT_LOCKED]  = locked_ff;
            `PLC_OFS_IRQ_STAT:  nxt_rdata[2:0] = irq_stat_ff;
            `PLC_OFS_IRQ_MASK:  nxt_rdata[2:0] = irq_mask_ff;
            `PLC_OFS_CLK_INFO: begin
                nxt_rdata[8:0]  = {fb_div_ff, 1'b0};
                nxt_rdata[16]   = cal.cal_busy;
                nxt_rdata[19:17] = cal.auto_code;
            end
            default:            nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o             <= 32'h0000_0000;
            pll_sel_o           <= 1'b0;
            pump_current_code_o <= `PLC_ICP_RESET;
            // Product tracks the reset divide value, so it reads 2N from the first edge
            pll_mult_o          <= {`PLC_N_RESET, 1'b0};
            vco_cal_busy_o      <= 1'b0;
            dac_cal_start_o     <= 1'b0;
            irq_o               <= 1'b0;
        end else if (en_i) begin
            rdata_o   <= rd_i ? nxt_rdata : 32'h0000_0000;
            pll_sel_o <= pll_en_ff;
            pump_current_code_o <= man_icp_ff ? icp_ff : cal.auto_code;
            pll_mult_o      <= {fb_div_ff, 1'b0};
            vco_cal_busy_o  <= cal.cal_busy;
            dac_cal_start_o <= dac_req_d_ff && !dac_req_ff;
            irq_o           <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // doubled multiplier
    mult_twice_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i |=> pll_mult_o == {$past(fb_div_ff), 1'b0})
        else $error("multiplier is not twice the divide value");
    man_code_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (en_i && man_icp_ff) |=> pump_current_code_o == $past(icp_ff))
        else $error("manual pump code not applied");
    auto_code_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (en_i && !man_icp_ff) |=> pump_current_code_o == $past(cal.auto_code))
        else $error("automatic pump code not applied");
    lock_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (en_i && !(lock_en_ff && pll_en_ff)) |=> !locked_ff)
        else $error("lock shown while detection off");
    lock_rise_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(locked_ff) |-> $past(lock_ok) && $past(lock_cnt_ff) == 16'(LOCK_CYC - 1))
        else $error("lock set without settled input");
    src_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        en_i |=> pll_sel_o == $past(pll_en_ff))
        else $error("clock source select wrong");
    cal_len_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (cal.cal_busy && en_i && cal_cnt_ff == 16'(VCO_CAL_CYC - 1)) |=> cal.cal_done)
        else $error("calibration did not finish on time");
    div_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (en_i && rd_i && addr_i == `PLC_OFS_CW_THIRD) |=> rdata_o[15:8] == $past(fb_div_ff))
        else $error("divide field read back wrong");

    cal_run_c:  cover property (@(posedge clk_i) disable iff (!reset_n_i) cal.cal_done);
    lock_c:     cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(locked_ff));
    manual_c:   cover property (@(posedge clk_i) disable iff (!reset_n_i) man_icp_ff && pll_en_ff);
    irq_c:      cover property (@(posedge clk_i) disable iff (!reset_n_i) irq_o);
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the PLL calibration control block.
// Assumes plc_top with short calibration and lock counts, driven over its register port.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_i;
    logic        reset_n_i;
    logic        en_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic        pll_lock_raw_i;
    logic        pll_sel_o;
    logic [2:0]  pump_current_code_o;
    logic [8:0]  pll_mult_o;
    logic        vco_cal_busy_o;
    logic        dac_cal_start_o;
    logic        irq_o;
    int          err_count;
    int          compares;
    logic [7:0]  ntab [8] = '{8'h0c, 8'h14, 8'h1e, 8'h28, 8'h32, 8'h3c, 8'h46, 8'h5a};

    plc_top #(.VCO_CAL_CYC(4), .LOCK_CYC(4)) u_plc_top (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .en_i                (en_i),
        .addr_i              (addr_i),
        .wdata_i             (wdata_i),
        .wr_i                (wr_i),
        .rd_i                (rd_i),
        .rdata_o             (rdata_o),
        .pll_lock_raw_i      (pll_lock_raw_i),
        .pll_sel_o           (pll_sel_o),
        .pump_current_code_o (pump_current_code_o),
        .pll_mult_o          (pll_mult_o),
        .vco_cal_busy_o      (vco_cal_busy_o),
        .dac_cal_start_o     (dac_cal_start_o),
        .irq_o               (irq_o)
    );

    // ----------------------------------------
    // Clock and bus tasks
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // Third control word: PLL enable, divide value, manual pump, pump code, lock enable
    function automatic logic [31:0] cw3(input logic [7:0] n, input logic pll, input logic man,
                                        input logic [2:0] code, input logic lck);
        return (32'(pll) << 18) | (32'(n) << 8) | (32'(man) << 6) | (32'(code) << 3) | (32'(lck) << 2);
    endfunction

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (vco_cal_busy_o !== lvl && n < 100) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk(32'(n < 100), 32'h1);
    endtask

    // Request bit is cleared first so that every run starts from a fresh rising edge
    // Reference input is taken as stable from reset onward
    task automatic run_cal();
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h0100_0000);
        wait_busy(1'b1);
        wait_busy(1'b0);
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog: the whole sequence needs well under 3000 cycles
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        err_count      = 0;
        compares       = 0;
        reset_n_i      = 1'b0;
        en_i           = 1'b1;
        addr_i         = 8'h00;
        wdata_i        = 32'h0;
        wr_i           = 1'b0;
        rd_i           = 1'b0;
        pll_lock_raw_i = 1'b0;
        repeat (16) @(posedge clk_i);
        chk(32'(pump_current_code_o), 32'h3);
        reset_n_i <= 1'b1;
        // Reset defaults: direct clock path, N of 10, pump code 3
        rd(8'h02, cw3(8'h0a, 1'b0, 1'b0, 3'h3, 1'b0));
        chk(32'(pll_sel_o), 32'h0);
        chk(32'(pll_mult_o), 32'h14);
        rd(8'h10, 32'h0);
        // Manual pump code, every value, each at a divide value that suits it
        for (int i = 0; i < 8; i++) begin
            wr(8'h02, cw3(ntab[i], 1'b1, 1'b1, 3'(i), 1'b0));
            @(posedge clk_i);
            #1;
            chk(32'(pump_current_code_o), 32'(i));
            chk(32'(pll_mult_o), 32'({ntab[i], 1'b0}));
            chk(32'(pll_sel_o), 32'h1);
        end
        // Automatic pump code per divide range; manual code 3 is ignored; every N is 10 or more
        for (int i = 0; i < 8; i++) begin
            wr(8'h02, cw3(ntab[i], 1'b0, 1'b0, 3'h3, 1'b0));
            run_cal();
            rd(8'h22, (32'(i) << 17) | 32'({ntab[i], 1'b0}));
            chk(32'(pump_current_code_o), 32'(i));
        end
        chk(32'(irq_o), 32'h0);
        // Holding the request bit high must not start another run
        wr(8'h00, 32'h0100_0000);
        repeat (10) @(posedge clk_i);
        #1;
        chk(32'(vco_cal_busy_o), 32'h0);
        // DAC start is not gated by VCO calibration state; pulse follows the clearing write
        wr(8'h03, 32'h0100_0000);
        wr(8'h03, 32'h0);
        #1;
        chk(32'(dac_cal_start_o), 32'h0);
        @(posedge clk_i);
        #1;
        chk(32'(dac_cal_start_o), 32'h1);
        @(posedge clk_i);
        #1;
        chk(32'(dac_cal_start_o), 32'h0);
        // A write while the clock enable is low is ignored
        @(posedge clk_i);
        en_i <= 1'b0;
        wr(8'h21, 32'h7);
        en_i <= 1'b1;
        rd(8'h21, 32'h0);
        // Interrupt: clear, unmask, raise, clear again
        wr(8'h20, 32'h7);
        rd(8'h20, 32'h0);
        wr(8'h21, 32'h1);
        rd(8'h21, 32'h1);
        run_cal();
        repeat (2) @(posedge clk_i);
        #1;
        chk(32'(irq_o), 32'h1);
        rd(8'h20, 32'h1);
        wr(8'h20, 32'h1);
        repeat (2) @(posedge clk_i);
        #1;
        chk(32'(irq_o), 32'h0);
        // Lock indication with detection enabled and PLL selected
        wr(8'h02, cw3(8'h28, 1'b1, 1'b0, 3'h3, 1'b1));
        pll_lock_raw_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rd(8'h1b, 32'h0100_0000);
        rd(8'h20, 32'h2);
        // Detection off, then PLL path off: no stale lock
        wr(8'h02, cw3(8'h28, 1'b1, 1'b0, 3'h3, 1'b0));
        repeat (3) @(posedge clk_i);
        rd(8'h1b, 32'h0);
        rd(8'h20, 32'h6);
        wr(8'h02, cw3(8'h28, 1'b1, 1'b0, 3'h3, 1'b1));
        repeat (20) @(posedge clk_i);
        rd(8'h1b, 32'h0100_0000);
        wr(8'h02, cw3(8'h28, 1'b0, 1'b0, 3'h3, 1'b1));
        repeat (3) @(posedge clk_i);
        rd(8'h1b, 32'h0);
        chk(32'(pll_sel_o), 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
